// File: src/sfpe_flash_ctrl.sv
`timescale 1ns/100ps
module sfpe_flash_ctrl
  import sfpe_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES,
  parameter int unsigned SSE_CYC = SUBSECTOR_ERASE_CYCLES,
  parameter int unsigned SE_CYC = SECTOR_ERASE_CYCLES,
  parameter int unsigned BE_CYC = WHOLE_DEVICE_ERASE_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic rst_b,
  // Serial link
  input wire logic csB,
  input wire logic sclk,
  input wire logic [3:0] dqIn,
  // Configuration
  input wire logic [1:0] laneMode,
  input wire logic [SECTORS-1:0] sectorLock,
  // Array port
  input wire logic [7:0] arrayRdData,
  input wire logic arrayVerifyOk,
  output logic [23:0] arrayAddr,
  output logic [7:0] arrayWrData,
  output logic arrayWrEn,
  output logic arrayEraseEn,
  output logic [1:0] arrayEraseSize,
  // Status
  output logic wipFlag,
  output logic welFlag,
  output logic [7:0] flagStatus
);

  // Link synchronisers
  logic [2:0] csSync_q;
  logic [2:0] sclkSync_q;
  logic [3:0] dqMeta_q;
  logic [3:0] dqSync_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csSync_q <= 3'h7;
      sclkSync_q <= 3'h0;
      dqMeta_q <= 4'h0;
      dqSync_q <= 4'h0;
    end else begin
      csSync_q <= {csSync_q[1:0], csB};
      sclkSync_q <= {sclkSync_q[1:0], sclk};
      dqMeta_q <= dqIn;
      dqSync_q <= dqMeta_q;
    end
  end

  wire csActive = ~csSync_q[1];
  wire csRise = csSync_q[1] & ~csSync_q[2];
  wire sclkRise = sclkSync_q[1] & ~sclkSync_q[2];
  wire bitStrobe = csActive && sclkRise;

  // Frame receiver
  sfpe_frame_e frame_q;
  sfpe_frame_e frame_d;
  logic [7:0] cmd_q;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;
  logic [23:0] addr_q;
  logic [1:0] addrBytes_q;
  logic addrDone_q;
  logic [8:0] dataCnt_q;

  wire [1:0] lanes = phaseLanes(laneMode, frame_q == FR_ADDR, frame_q == FR_DATA, cmd_q);
  wire [3:0] laneStep = (lanes == LANE_4) ? 4'h4 : (lanes == LANE_2) ? 4'h2 : 4'h1;
  wire [7:0] shiftNext = (lanes == LANE_4) ? {shift_q[3:0], dqSync_q} :
                         (lanes == LANE_2) ? {shift_q[5:0], dqSync_q[1:0]} :
                         {shift_q[6:0], dqSync_q[0]};
  wire [3:0] bitSum = bitCnt_q + laneStep;
  wire byteDone = bitStrobe && (bitSum == BITS_PER_BYTE);
  wire cmdByte = byteDone && (frame_q == FR_CMD);
  wire addrByte = byteDone && (frame_q == FR_ADDR);
  wire dataByte = byteDone && (frame_q == FR_DATA);
  wire [7:0] bufIdx = addr_q[7:0] + dataCnt_q[7:0];

  always_comb begin
    frame_d = frame_q;
    case (frame_q)
      FR_CMD: begin
        if (byteDone) begin
          frame_d = (isProgCode(shiftNext) || isRegionEraseCode(shiftNext)) ? FR_ADDR : FR_SKIP;
        end
      end
      FR_ADDR: begin
        if (byteDone && addrBytes_q == ADDR_LAST) begin
          frame_d = isProgCode(cmd_q) ? FR_DATA : FR_SKIP;
        end
      end
      FR_DATA: frame_d = FR_DATA;
      FR_SKIP: frame_d = FR_SKIP;
      default: frame_d = FR_CMD;
    endcase
  end

  // Chip select high ends any frame at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= FR_CMD;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (!csActive) begin
      frame_q <= FR_CMD;
      bitCnt_q <= 4'h0;
    end else if (bitStrobe) begin
      frame_q <= frame_d;
      shift_q <= shiftNext;
      bitCnt_q <= byteDone ? 4'h0 : bitSum;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= 8'h00;
      addr_q <= 24'h000000;
      addrBytes_q <= 2'h0;
      addrDone_q <= 1'b0;
      dataCnt_q <= 9'h000;
    end else if (!csActive) begin
      addrBytes_q <= 2'h0;
      addrDone_q <= 1'b0;
      dataCnt_q <= 9'h000;
    end else begin
      if (cmdByte) cmd_q <= shiftNext;
      if (addrByte) begin
        addr_q <= {addr_q[15:0], shiftNext};
        addrBytes_q <= addrBytes_q + 2'h1;
        addrDone_q <= (addrBytes_q == ADDR_LAST);
      end
      if (dataByte && dataCnt_q != PAGE_BYTES) dataCnt_q <= dataCnt_q + 9'h001;
    end
  end

  // Command evaluation at the chip select rise; clear-flags, suspend and resume at their command byte
  logic wel_q;
  logic wip_q;
  logic ready_q;
  logic eraseSusp_q;
  logic eraseErr_q;
  logic progErr_q;
  logic protErr_q;
  logic opIsErase_q;
  logic opBulk_q;
  logic [7:0] suspSect_q;
  logic [TMR_W-1:0] suspRemain_q;
  logic wrActive_q;
  logic timerDone;
  logic [TMR_W-1:0] timerRemain;

  wire [7:0] sect = addr_q[23:16];
  wire aligned = (bitCnt_q == 4'h0);
  wire cmdIsProg = isProgCode(cmd_q);
  wire cmdIsRegion = isRegionEraseCode(cmd_q);
  wire cmdIsBulk = isBulkCode(cmd_q);
  // Only whole bytes after a complete header count
  wire frameOk = aligned && (cmdIsProg ? (frame_q == FR_DATA && dataCnt_q != 9'h000) :
                             cmdIsBulk ? (frame_q != FR_CMD) : addrDone_q);
  wire progReq = csRise && cmdIsProg && frameOk && wel_q && !wip_q;
  wire progLockHit = sectorLock[sect];
  wire progSuspHit = eraseSusp_q && (suspSect_q == sect);
  wire progProtFire = progReq && progLockHit;
  wire progSuspFire = progReq && !progLockHit && progSuspHit;
  wire startProg = progReq && !progLockHit && !progSuspHit;
  wire eraseReq = csRise && (cmdIsRegion || cmdIsBulk) && frameOk && wel_q && !wip_q &&
                  !eraseSusp_q;
  wire eraseLockHit = cmdIsBulk ? (|sectorLock) : sectorLock[sect];
  wire eraseProtFire = eraseReq && eraseLockHit;
  wire startErase = eraseReq && !eraseLockHit;
  wire clrFlags = cmdByte && (shiftNext == CMD_CLR_FLAGS);
  wire suspendCmd = cmdByte && (shiftNext == CMD_SUSPEND) && wip_q && opIsErase_q &&
                    !opBulk_q && !timerDone;
  wire resumeCmd = cmdByte && (shiftNext == CMD_RESUME) && eraseSusp_q && !wip_q;
  wire weSet = csRise && aligned && frame_q != FR_CMD && cmd_q == CMD_WREN;
  // A pending protection error keeps the latch against write disable until flags are cleared; an operation end still clears it
  wire weClr = csRise && aligned && frame_q != FR_CMD && cmd_q == CMD_WRDI && !protErr_q;
  wire opDone = timerDone && wip_q;
  wire opFail = opDone && !arrayVerifyOk;
  wire [1:0] eraseSize = eraseSizeOf(cmd_q);
  wire [TMR_W-1:0] eraseCyc = cmdIsBulk ? BE_CYC[TMR_W-1:0] :
                              (cmd_q == CMD_SE) ? SE_CYC[TMR_W-1:0] : SSE_CYC[TMR_W-1:0];
  wire [TMR_W-1:0] timerLoad = startProg ? PROG_CYC[TMR_W-1:0] :
                               startErase ? eraseCyc : suspRemain_q;
  wire [23:0] eraseBase = (eraseSize == ERSZ_4K) ? {addr_q[23:12], 12'h000} :
                          (eraseSize == ERSZ_32K) ? {addr_q[23:15], 15'h0000} :
                          (eraseSize == ERSZ_64K) ? {addr_q[23:16], 16'h0000} :
                          24'h000000;

  sfpe_op_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(startProg || startErase || resumeCmd),
    .stop(suspendCmd),
    .loadVal(timerLoad),
    .done(timerDone),
    .running(),
    .remaining(timerRemain)
  );

  // Latch and busy flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wel_q <= WEL_RST;
      wip_q <= WIP_RST;
      ready_q <= READY_RST;
    end else begin
      if (weSet) wel_q <= 1'b1;
      if (weClr || opDone) wel_q <= 1'b0;
      if (startProg || startErase || resumeCmd) begin
        wip_q <= 1'b1;
        ready_q <= 1'b0;
      end
      if (opDone || suspendCmd) begin
        wip_q <= 1'b0;
        ready_q <= 1'b1;
      end
    end
  end

  // Error flags: a set in the clear cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eraseErr_q <= 1'b0;
      progErr_q <= 1'b0;
      protErr_q <= 1'b0;
    end else begin
      if (clrFlags) begin
        eraseErr_q <= 1'b0;
        progErr_q <= 1'b0;
        protErr_q <= 1'b0;
      end
      if (progProtFire || eraseProtFire) protErr_q <= 1'b1;
      if (progProtFire || progSuspFire) progErr_q <= 1'b1;
      if (opFail && !opIsErase_q) progErr_q <= 1'b1;
      if (eraseProtFire || (opFail && opIsErase_q)) eraseErr_q <= 1'b1;
    end
  end

  // Operation context and erase suspension
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opIsErase_q <= 1'b0;
      opBulk_q <= 1'b0;
      eraseSusp_q <= 1'b0;
      suspSect_q <= 8'h00;
      suspRemain_q <= '0;
    end else begin
      if (startProg) opIsErase_q <= 1'b0;
      if (startErase) begin
        opIsErase_q <= 1'b1;
        opBulk_q <= cmdIsBulk;
        suspSect_q <= sect;
      end
      if (suspendCmd) begin
        eraseSusp_q <= 1'b1;
        suspRemain_q <= timerRemain;
      end
      if (resumeCmd) begin
        eraseSusp_q <= 1'b0;
        opIsErase_q <= 1'b1;
      end
    end
  end

  // Page buffer and array write-back
  logic [7:0] pageBuf [PAGE_BYTES];
  logic wrPhase_q;
  logic [8:0] wrIdx_q;
  logic [8:0] wrCnt_q;
  logic [23:0] progAddr_q;
  logic [23:0] arrayAddr_q;
  logic [7:0] arrayWrData_q;
  logic arrayWrEn_q;
  logic arrayEraseEn_q;
  logic [1:0] arrayEraseSize_q;

  wire [7:0] wrOff = progAddr_q[7:0] + wrIdx_q[7:0];
  wire [8:0] wrIdxNext = wrIdx_q + 9'h001;

  // Only idle frames may refill the buffer; every byte beyond a page lands on the start offset
  always_ff @(posedge clk) begin
    if (dataByte && !wip_q && !wrActive_q) pageBuf[bufIdx] <= shiftNext;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrActive_q <= 1'b0;
      wrPhase_q <= 1'b0;
      wrIdx_q <= 9'h000;
      wrCnt_q <= 9'h000;
      progAddr_q <= 24'h000000;
    end else if (startProg) begin
      wrActive_q <= 1'b1;
      wrPhase_q <= 1'b0;
      wrIdx_q <= 9'h000;
      wrCnt_q <= dataCnt_q;
      progAddr_q <= addr_q;
    end else if (wrActive_q) begin
      wrPhase_q <= ~wrPhase_q;
      if (wrPhase_q) begin
        wrIdx_q <= wrIdxNext;
        wrActive_q <= (wrIdxNext != wrCnt_q);
      end
    end
  end

  // Address phase, then read-modify-write of one byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arrayAddr_q <= 24'h000000;
      arrayWrData_q <= 8'hFF;
      arrayWrEn_q <= 1'b0;
      arrayEraseEn_q <= 1'b0;
      arrayEraseSize_q <= ERSZ_4K;
    end else begin
      arrayWrEn_q <= wrActive_q && wrPhase_q;
      arrayEraseEn_q <= startErase;
      if (wrActive_q && !wrPhase_q) arrayAddr_q <= {progAddr_q[23:8], wrOff};
      if (wrActive_q && wrPhase_q) arrayWrData_q <= arrayRdData & pageBuf[wrOff];
      if (startErase) begin
        arrayAddr_q <= eraseBase;
        arrayEraseSize_q <= eraseSize;
      end
    end
  end

  assign arrayAddr = arrayAddr_q;
  assign arrayWrData = arrayWrData_q;
  assign arrayWrEn = arrayWrEn_q;
  assign arrayEraseEn = arrayEraseEn_q;
  assign arrayEraseSize = arrayEraseSize_q;
  assign wipFlag = wip_q;
  assign welFlag = wel_q;
  assign flagStatus = {ready_q, eraseSusp_q, eraseErr_q, progErr_q, 2'h0, protErr_q, 1'b0};

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_busy_on;
    wipFlag && !flagStatus[7];
  endsequence
  sequence s_idle_no_latch;
    !wipFlag && flagStatus[7] && !welFlag;
  endsequence

  a_clear_flags: assert property (clrFlags && !progProtFire && !eraseProtFire
    && !progSuspFire && !opFail |=> flagStatus[5:4] == 2'h0 && !flagStatus[1])
    else $error("error flags not cleared");
  a_frame_end: assert property (csRise |=> frame_q == FR_CMD && bitCnt_q == 4'h0)
    else $error("frame not ended by chip select");
  a_misaligned_nop: assert property (csRise && !aligned && wel_q && !wip_q
    && !timerDone |=> welFlag && !wipFlag && $stable(flagStatus))
    else $error("misaligned command had an effect");
  // Chip select high may only return the count to zero
  a_bit_sample: assert property (!sclkRise |=> $stable(bitCnt_q)
    || (csSync_q[2] && bitCnt_q == 4'h0))
    else $error("bit taken without serial clock rise");
  a_prog_protect: assert property (progProtFire |=> welFlag && flagStatus[1]
    && flagStatus[4] && !wipFlag)
    else $error("protected program mishandled");
  a_prog_fail: assert property (opFail && !opIsErase_q |=> !welFlag && flagStatus[4])
    else $error("program timeout not flagged");
  a_prog_merge: assert property (wrActive_q && wrPhase_q && !startProg
    |=> arrayWrEn && (arrayWrData & ~$past(arrayRdData)) == 8'h00)
    else $error("program raised an array bit");
  a_prog_busy: assert property (startProg |=> s_busy_on ##1 wipFlag)
    else $error("busy not held during program");
  a_op_end: assert property (opDone |=> s_idle_no_latch)
    else $error("operation end left latch or busy set");
  a_erase_nowel: assert property (csRise && cmdIsRegion && frameOk && !wel_q
    && !wip_q |=> !wipFlag && !arrayEraseEn && $stable(flagStatus[5:1]))
    else $error("erase without latch not ignored");
  a_erase_protect: assert property (eraseProtFire |=> welFlag && flagStatus[5]
    && flagStatus[1] && !arrayEraseEn)
    else $error("protected erase mishandled");
  a_erase_busy: assert property (startErase |=> s_busy_on and arrayEraseEn)
    else $error("erase start flags wrong");
  a_erase_fail: assert property (opFail && opIsErase_q |=> !welFlag && flagStatus[5])
    else $error("erase timeout not flagged");
  a_erase_align: assert property (startErase && cmd_q == CMD_SSE_4K
    |=> arrayEraseEn && arrayAddr[11:0] == 12'h000)
    else $error("subsector erase base not aligned");
  a_bulk_locked: assert property (eraseReq && cmdIsBulk && (|sectorLock)
    |=> !wipFlag && flagStatus[5] && welFlag)
    else $error("whole erase ran with locked sector");
  a_suspend: assert property (suspendCmd
    |=> flagStatus[6] && !wipFlag && flagStatus[7])
    else $error("erase suspend not entered");
  a_busy_reject: assert property (csRise && wip_q && !timerDone
    && (cmdIsProg || cmdIsRegion || cmdIsBulk) |=> wipFlag && !arrayEraseEn
    && welFlag == $past(welFlag))
    else $error("command accepted while busy");

endmodule // sfpe_flash_ctrl

// File: src/sfpe_op_timer.sv
`timescale 1ns/100ps
module sfpe_op_timer
  import sfpe_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [TMR_W-1:0] loadVal,
  // Result
  output logic done,
  output logic running,
  output logic [TMR_W-1:0] remaining
);

  logic done_q;
  logic running_q;
  logic [TMR_W-1:0] remaining_q;
  wire lastTick = running_q && (remaining_q <= {{(TMR_W-1){1'b0}}, 1'b1});

  // Stop keeps the count so a suspended erase can pick it up later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      running_q <= 1'b0;
      remaining_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        running_q <= 1'b1;
        remaining_q <= loadVal;
      end else if (stop) begin
        running_q <= 1'b0;
      end else if (lastTick) begin
        running_q <= 1'b0;
        remaining_q <= '0;
        done_q <= 1'b1;
      end else if (running_q) begin
        remaining_q <= remaining_q - {{(TMR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign done = done_q;
  assign running = running_q;
  assign remaining = remaining_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_timer_load: assert property (start |=> running_q && remaining_q == $past(loadVal))
    else $error("timer did not load its duration");
  a_timer_step: assert property (running_q && !start && !stop && !lastTick
                                 |=> remaining_q == $past(remaining_q) - 1)
    else $error("timer did not count down by one");

endmodule // sfpe_op_timer

// File: src/sfpe_pkg.sv
// Function
// - Clear-flags command resets all three error flags
// - Command width follows protocol; chip select ends it
// - Misaligned chip select rise: nothing executed, latch kept; clear-flags, suspend, resume run at command byte
// - Address bits sampled on serial clock rising edge
// - Protected program: latch kept, bits 1, 4 set
// - Program timeout clears latch, sets program fail
// - Program only turns array bits one to zero
// - Five program codes: 02, A2, D2, 32, 38
// - Write-in-progress high while program runs
// - Every operation end clears write enable latch
// - Erase sets bits to one; 52/20, D8, C7/60
// - Erase without write enable ignored silently
// - Protected subsector erase: latch kept, bits 1, 5
// - Erase drives controller ready low, busy high
// - Erase timeout clears latch, sets erase error
// - Region erase takes any address, fills region
// - Whole erase refused if any sector locked
// - Region erases suspend and resume on command
// - Erases self-timed with three separate durations
// - Flag bit 4 marks program fail and protection
package sfpe_pkg;

  // Command codes
  localparam logic [7:0] CMD_CLR_FLAGS = 8'h50;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_DUAL_PP = 8'hA2;
  localparam logic [7:0] CMD_XDUAL_PP = 8'hD2;
  localparam logic [7:0] CMD_QUAD_PP = 8'h32;
  localparam logic [7:0] CMD_XQUAD_PP = 8'h38;
  localparam logic [7:0] CMD_SSE_32K = 8'h52;
  localparam logic [7:0] CMD_SSE_4K = 8'h20;
  localparam logic [7:0] CMD_SE = 8'hD8;
  localparam logic [7:0] CMD_BE_A = 8'hC7;
  localparam logic [7:0] CMD_BE_B = 8'h60;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;

  // Lane modes
  localparam logic [1:0] LANE_1 = 2'h0;
  localparam logic [1:0] LANE_2 = 2'h1;
  localparam logic [1:0] LANE_4 = 2'h2;

  // Erase region codes
  localparam logic [1:0] ERSZ_4K = 2'h0;
  localparam logic [1:0] ERSZ_32K = 2'h1;
  localparam logic [1:0] ERSZ_64K = 2'h2;
  localparam logic [1:0] ERSZ_ALL = 2'h3;

  // Frame layout
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam int SECTORS = 256;

  // Values after reset
  localparam logic WEL_RST = 1'b0;
  localparam logic WIP_RST = 1'b0;
  localparam logic READY_RST = 1'b1;

  // Timing
  localparam int CLK_MHZ = 40;
  localparam int PROG_TIME_US = 500;
  localparam int SUBSECTOR_ERASE_TIME_US = 2000;
  localparam int SECTOR_ERASE_TIME_US = 5000;
  localparam int WHOLE_DEVICE_ERASE_TIME_US = 100000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int SUBSECTOR_ERASE_CYCLES = SUBSECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int WHOLE_DEVICE_ERASE_CYCLES = WHOLE_DEVICE_ERASE_TIME_US * CLK_MHZ;
  localparam int TMR_W = 32;

  typedef enum logic [3:0] {
    FR_CMD = 4'h1,
    FR_ADDR = 4'h2,
    FR_DATA = 4'h4,
    FR_SKIP = 4'h8
  } sfpe_frame_e;

  function automatic logic isProgCode(input logic [7:0] c);
    return (c == CMD_PP) || (c == CMD_DUAL_PP) || (c == CMD_XDUAL_PP) ||
           (c == CMD_QUAD_PP) || (c == CMD_XQUAD_PP);
  endfunction

  function automatic logic isRegionEraseCode(input logic [7:0] c);
    return (c == CMD_SSE_32K) || (c == CMD_SSE_4K) || (c == CMD_SE);
  endfunction

  function automatic logic isBulkCode(input logic [7:0] c);
    return (c == CMD_BE_A) || (c == CMD_BE_B);
  endfunction

  function automatic logic [1:0] eraseSizeOf(input logic [7:0] c);
    logic [1:0] s;
    s = ERSZ_ALL;
    if (c == CMD_SSE_4K) s = ERSZ_4K;
    else if (c == CMD_SSE_32K) s = ERSZ_32K;
    else if (c == CMD_SE) s = ERSZ_64K;
    return s;
  endfunction

  // Extended protocol widens address or data lanes for some program codes
  function automatic logic [1:0] phaseLanes(input logic [1:0] proto, input logic inAddr,
                                            input logic inData, input logic [7:0] c);
    logic [1:0] w;
    w = proto;
    if (proto == LANE_1 && inData && (c == CMD_DUAL_PP || c == CMD_XDUAL_PP)) w = LANE_2;
    if (proto == LANE_1 && inData && (c == CMD_QUAD_PP || c == CMD_XQUAD_PP)) w = LANE_4;
    if (proto == LANE_1 && inAddr && c == CMD_XDUAL_PP) w = LANE_2;
    if (proto == LANE_1 && inAddr && c == CMD_XQUAD_PP) w = LANE_4;
    return w;
  endfunction

endpackage

// File: verification/sfpe_host_model.sv
`timescale 1ns/100ps
module sfpe_host_model
  import sfpe_pkg::*;
(
  // Link
  input wire logic clk,
  output logic csB,
  output logic sclk,
  output logic [3:0] dqIn
);
  initial begin
    csB = 1'b1;
    sclk = 1'b0;
    dqIn = 4'h0;
  end
  // Lanes move while the clock is low so every rise sees settled data
  task automatic shiftBits(input logic [7:0] b, input int w, input int n);
    logic [7:0] sh;
    sh = b;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      dqIn = 4'(sh >> (8 - w));
      sh = sh << w;
      #100;
      sclk = 1'b1;
      #100;
    end
  endtask
  task automatic frame(input logic [7:0] c, input int cw, input int na, input logic [23:0] a,
                       input int nd, input logic [7:0] d, input int extra);
    int aw;
    int dw;
    aw = (c == CMD_XDUAL_PP) ? 2 : (c == CMD_XQUAD_PP) ? 4 : cw;
    dw = (c == CMD_DUAL_PP || c == CMD_XDUAL_PP) ? 2 : aw;
    dw = (c == CMD_QUAD_PP) ? 4 : dw;
    @(negedge clk);
    csB = 1'b0;
    #100;
    shiftBits(c, cw, 8 / cw);
    for (int i = 0; i < na; i++) shiftBits(a[23 - 8 * i -: 8], aw, 8 / aw);
    for (int i = 0; i < nd; i++) shiftBits(d, dw, 8 / dw);
    shiftBits(8'hFF, 1, extra);
    sclk = 1'b0;
    #100;
    csB = 1'b1;
    dqIn = ~dqIn;
  endtask
endmodule // sfpe_host_model

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import sfpe_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic csB, sclk, arrayWrEn, arrayEraseEn, wipFlag, welFlag;
  logic [3:0] dqIn;
  logic [1:0] laneMode = LANE_1;
  logic [1:0] arrayEraseSize;
  logic [SECTORS-1:0] sectorLock = '0;
  logic [7:0] arrayRdData = 8'h00;
  logic arrayVerifyOk = 1'b1;
  logic [23:0] arrayAddr;
  logic [7:0] arrayWrData, flagStatus, wrSeen, d;
  logic [7:0] lf = 8'h60;
  logic [7:0] progCodes [5] = '{CMD_PP, CMD_DUAL_PP, CMD_XDUAL_PP, CMD_QUAD_PP, CMD_XQUAD_PP};
  int n_mismatch = 0;
  int total_checks = 0;
  int nErase = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (arrayWrEn === 1'b1) wrSeen <= arrayWrData;
  always @(posedge clk) if (arrayEraseEn === 1'b1) nErase <= nErase + 1;
  // Short op times keep the run small; sector erase outlasts a suspend frame
  sfpe_flash_ctrl #(.PROG_CYC(20), .SSE_CYC(50), .SE_CYC(300), .BE_CYC(50)) i_sfpe_flash_ctrl (
    .clk(clk), .rst_b(rst_b), .csB(csB), .sclk(sclk), .dqIn(dqIn), .laneMode(laneMode),
    .sectorLock(sectorLock), .arrayRdData(arrayRdData), .arrayVerifyOk(arrayVerifyOk),
    .arrayAddr(arrayAddr), .arrayWrData(arrayWrData), .arrayWrEn(arrayWrEn),
    .arrayEraseEn(arrayEraseEn), .arrayEraseSize(arrayEraseSize), .wipFlag(wipFlag),
    .welFlag(welFlag), .flagStatus(flagStatus));
  sfpe_host_model i_sfpe_host_model (.clk(clk), .csB(csB), .sclk(sclk), .dqIn(dqIn));
  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [8:0] doneFlags(input logic ok);
    return ok ? 9'h080 : 9'h090;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic op(input logic [7:0] c, input int cw, input int na, input logic [23:0] a,
                    input int nd, input logic [7:0] dd, input int extra);
    i_sfpe_host_model.frame(c, cw, na, a, nd, dd, extra);
    repeat (6) @(negedge clk);
  endtask
  task automatic waitIdle();
    int k;
    for (k = 0; k < 400 && wipFlag !== 1'b0; k++) @(negedge clk);
    if (k == 400) begin
      chk("idle wait", 0, 1);
      print_verdict();
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset state", 10'h080, {wipFlag, welFlag, flagStatus});
    op(CMD_SSE_4K, 1, 3, 24'h010000, 0, 0, 0);
    chk("erase no latch", 10'h080, {wipFlag, welFlag, flagStatus});
    for (int k = 0; k < 5; k++) begin
      lf = nextRand(lf);
      d = lf;
      lf = nextRand(lf);
      arrayRdData = lf;
      arrayVerifyOk = (k != 4);
      op(CMD_WREN, 1, 0, 0, 0, 0, 0);
      op(progCodes[k], 1, 3, {8'h01, lf, d}, 1, d, 0);
      chk("busy in program", 1, wipFlag);
      waitIdle();
      chk("merged byte", arrayRdData & d, wrSeen);
      chk("program end", doneFlags(k != 4), {welFlag, flagStatus});
    end
    op(CMD_CLR_FLAGS, 1, 0, 0, 0, 0, 0);
    chk("clear flags", 8'h80, flagStatus);
    sectorLock[5] = 1'b1;
    op(CMD_WREN, 1, 0, 0, 0, 0, 0);
    op(CMD_PP, 1, 3, 24'h050010, 1, 8'h3C, 0);
    chk("locked program", 9'h192, {welFlag, flagStatus});
    laneMode = LANE_2;
    op(CMD_CLR_FLAGS, 2, 0, 0, 0, 0, 0);
    chk("clear dual", 9'h180, {welFlag, flagStatus});
    laneMode = LANE_1;
    op(CMD_SE, 1, 3, 24'h05ABCD, 0, 0, 0);
    chk("locked erase", 9'h1A2, {welFlag, flagStatus});
    laneMode = LANE_4;
    op(CMD_CLR_FLAGS, 4, 0, 0, 0, 0, 0);
    chk("clear quad", 9'h180, {welFlag, flagStatus});
    laneMode = LANE_1;
    op(CMD_BE_B, 1, 0, 0, 0, 0, 0);
    chk("locked whole", 9'h1A2, {welFlag, flagStatus});
    op(CMD_CLR_FLAGS, 1, 0, 0, 0, 0, 0);
    sectorLock = '0;
    op(CMD_PP, 1, 3, 24'h020000, 1, 8'h00, 3);
    chk("unaligned end", 10'h180, {wipFlag, welFlag, flagStatus});
    arrayVerifyOk = 1'b1;
    op(CMD_SE, 1, 3, 24'h060000, 0, 0, 0);
    op(CMD_SUSPEND, 1, 0, 0, 0, 0, 0);
    chk("suspend", 3'b011, {wipFlag, flagStatus[7:6]});
    op(CMD_PP, 1, 3, 24'h061234, 1, 8'h55, 0);
    chk("suspended sector", 9'h1D0, {welFlag, flagStatus});
    op(CMD_RESUME, 1, 0, 0, 0, 0, 0);
    chk("resume", 3'b100, {wipFlag, flagStatus[7:6]});
    waitIdle();
    chk("resumed end", 9'h090, {welFlag, flagStatus});
    op(CMD_CLR_FLAGS, 1, 0, 0, 0, 0, 0);
    op(CMD_WREN, 1, 0, 0, 0, 0, 0);
    arrayVerifyOk = 1'b0;
    lf = nextRand(lf);
    op(CMD_SSE_4K, 1, 3, {8'h03, lf, 8'h77}, 0, 0, 0);
    chk("erase busy", 2'b10, {wipFlag, flagStatus[7]});
    chk("erase base", {8'h03, lf[7:4], 12'h000}, arrayAddr);
    chk("erase size", ERSZ_4K, arrayEraseSize);
    waitIdle();
    chk("erase timeout", 9'h0A0, {welFlag, flagStatus});
    chk("erase starts", 2, nErase);
    print_verdict();
  end
endmodule // tb
